// [src/css_sequencer.sv]
// column sampling sequencer: shift token, colour multiplexer, two hold banks
// Overview of operation
// - start pulse is taken on the rising edge of phase one in both schemes.
// - successive sampling steps on all three phases, simultaneous on phase one only.
// - right shift reads the right cascade pin, drives the left; left shift swaps.
// - falling line strobe advances colour counter and swaps the two banks.
// - reset clears the colour counter and the bank selector.
// - after reset no delta or mosaic sampling until one line strobe; controller model sends none in the first line.
// - select pins decode to stripe, single delta, mosaic, double delta.
// - direction high scans column 1 to 240, low scans 240 to 1.
// - stripe samples simultaneously; delta and mosaic sample successively.
// - stripe passes a, b, c straight through, sampling even before the first line strobe.
// - single delta uses a,b,c on odd counts and b,c,a on even ones.
// - double delta right b,c,a then a,b,c; left reversed from column 240.
// - mosaic rotates a,b,c then c,a,b then b,c,a every three counts.
// - one bank samples a line while the other drives the previous line.
// - column outputs float while line strobe is high, drive while low.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.svh"
module css_sequencer #(
    parameter int COLS = `CSS_COLS,
    parameter int W    = `CSS_VIDEO_W
) (
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    // timing from the controller
    input  wire logic [2:0]        shift_clock_phase_in,
    input  wire logic              line_strobe_in,
    // configuration straps
    input  wire logic              array_select_hi_in,
    input  wire logic              array_select_lo_in,
    input  wire logic              direction_right_in,
    // video
    input  wire logic [W-1:0]      video_in_a_in,
    input  wire logic [W-1:0]      video_in_b_in,
    input  wire logic [W-1:0]      video_in_c_in,
    // cascade pins
    input  wire logic              cascade_right_pin_in,
    output logic                   cascade_right_pin_out,
    output logic                   cascade_right_pin_oe_out,
    input  wire logic              cascade_left_pin_in,
    output logic                   cascade_left_pin_out,
    output logic                   cascade_left_pin_oe_out,
    // columns
    output logic [COLS*W-1:0]      column_outputs_out,
    output logic                   column_outputs_oe_out,
    output logic [COLS-1:0]        sampling_pulse_out
);
    css_pkg::css_cfg_t   cfg;
    css_pkg::css_phase_t phase;
    css_pkg::css_phase_t phase_prev;
    css_pkg::css_phase_t rise;
    logic                strobe_prev;
    logic                strobe_fall;
    logic                successive;
    logic                start_in;
    logic [COLS-1:0]     token;
    logic                carry;
    logic [2:0]          colour_cnt;
    logic [2:0]          next_colour_cnt;
    logic                bank_sel;
    logic                sample_ok;
    logic [1:0]          rot;
    logic [COLS-1:0]     col_strobe;
    logic [COLS-1:0]     wr_en0;
    logic [COLS-1:0]     wr_en1;
    logic [COLS*W-1:0]   wr_data;
    logic [COLS*W-1:0]   bank0_rd;
    logic [COLS*W-1:0]   bank1_rd;

    // input index for a group member under a rotation: 0=a, 1=b, 2=c
    function automatic logic [1:0] pick_idx(input logic [1:0] m, input logic [1:0] r);
        logic [2:0] s;
        s = {1'b0, m} + {1'b0, r};
        if (s >= 3'h3) begin
            s = s - 3'h3;
        end
        return s[1:0];
    endfunction

    assign cfg.right_shift = direction_right_in;
    assign cfg.array       = css_pkg::css_array_t'({array_select_hi_in, array_select_lo_in});
    assign phase           = css_pkg::css_phase_t'(shift_clock_phase_in);
    assign rise            = phase & ~phase_prev;
    assign strobe_fall     = strobe_prev & ~line_strobe_in;
    assign successive      = (cfg.array != css_pkg::CSS_STRIPE);

    // pin roles follow the direction strap
    assign start_in                 = cfg.right_shift ? cascade_right_pin_in
                                                      : cascade_left_pin_in;
    assign cascade_left_pin_out     = cfg.right_shift & carry;
    assign cascade_left_pin_oe_out  = cfg.right_shift;
    assign cascade_right_pin_out    = ~cfg.right_shift & carry;
    assign cascade_right_pin_oe_out = ~cfg.right_shift;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            phase_prev  <= '0;
            strobe_prev <= 1'b0;
        end else begin
            phase_prev  <= phase;
            strobe_prev <= line_strobe_in;
        end
    end

    // token index is scan position, not column number
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            token <= '0;
            carry <= 1'b0;
        end else if (successive) begin
            if (rise.p1) begin
                token <= {token[COLS-2:0], start_in};
                carry <= token[COLS-1];
            end else if (rise.p2 | rise.p3) begin
                token <= {token[COLS-2:0], 1'b0};
                carry <= token[COLS-1];
            end
        end else if (rise.p1) begin
            // a stray phase two or three edge is ignored here
            token <= {token[COLS-4:0], {3{start_in}}};
            carry <= token[COLS-1];
        end
    end
    assign sampling_pulse_out = token;

    always_comb begin
        next_colour_cnt = colour_cnt + 3'h1;
        if (colour_cnt == `CSS_CNT_LAST) begin
            next_colour_cnt = `CSS_CNT_FIRST;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            colour_cnt <= `CSS_CNT_RST;
            bank_sel   <= `CSS_BANK_RST;
        end else if (strobe_fall) begin
            colour_cnt <= next_colour_cnt;
            bank_sel   <= ~bank_sel;
        end
    end

    // count 0 means no strobe since reset: write enables off except in stripe
    assign sample_ok = (colour_cnt != `CSS_CNT_RST) || !successive;

    always_comb begin
        rot = 2'h0;
        case (cfg.array)
            css_pkg::CSS_STRIPE: rot = 2'h0;
            css_pkg::CSS_SINGLE: rot = colour_cnt[0] ? 2'h0 : 2'h1;
            css_pkg::CSS_MOSAIC: begin
                // column one steps a, c, b: the pattern slides one column per line
                if (colour_cnt == 3'h2 || colour_cnt == 3'h5) begin
                    rot = 2'h2;
                end else if (colour_cnt == 3'h3 || colour_cnt == 3'h6) begin
                    rot = 2'h1;
                end else begin
                    rot = 2'h0;
                end
            end
            css_pkg::CSS_DOUBLE: begin
                // the left scan sees the same colours in the other parity
                rot = (colour_cnt[0] ^ ~cfg.right_shift) ? 2'h1 : 2'h0;
            end
            default: rot = 2'h0;
        endcase
    end

    for (genvar c = 0; c < COLS; c++) begin : g_col
        localparam logic [1:0] MEMBER = 2'(c % `CSS_GROUP);
        logic [1:0] idx;
        assign col_strobe[c] = cfg.right_shift ? token[c] : token[COLS-1-c];
        assign idx = pick_idx(MEMBER, rot);
        assign wr_data[c*W +: W] = (idx == 2'h0) ? video_in_a_in :
                                   (idx == 2'h1) ? video_in_b_in : video_in_c_in;
    end

    assign wr_en0 = col_strobe & {COLS{sample_ok & ~bank_sel}};
    assign wr_en1 = col_strobe & {COLS{sample_ok & bank_sel}};

    css_hold_bank #(.COLS(COLS), .W(W)) u_bank0 (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (wr_en0),
        .wr_data_in  (wr_data),
        .rd_data_out (bank0_rd)
    );
    css_hold_bank #(.COLS(COLS), .W(W)) u_bank1 (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (wr_en1),
        .wr_data_in  (wr_data),
        .rd_data_out (bank1_rd)
    );

    // the bank not sampling drives the columns
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            column_outputs_out <= '0;
        end else begin
            column_outputs_out <= bank_sel ? bank0_rd : bank1_rd;
        end
    end
    assign column_outputs_oe_out = ~line_strobe_in;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    bank_swap_a: assert property (strobe_fall |=> bank_sel != $past(bank_sel))
        else $error("bank selector did not swap on strobe fall");
    count_wrap_a: assert property (strobe_fall && colour_cnt == 3'h6 |=> colour_cnt == 3'h1)
        else $error("colour counter did not wrap to one");
    reset_clear_a: assert property (disable iff (1'b0)
        sys_rst_in |=> colour_cnt == 3'h0 && bank_sel == 1'b0)
        else $error("reset did not clear counter and bank");
    no_early_a: assert property (colour_cnt == 3'h0 && successive |-> wr_en0 == '0 && wr_en1 == '0)
        else $error("sampling before first strobe");
    output_float_a: assert property (line_strobe_in |-> !column_outputs_oe_out)
        else $error("columns driven while strobe high");
    start_take_a: assert property (successive && rise.p1 && start_in |=> token[0])
        else $error("start pulse not captured");
    group_pulse_a: assert property (!successive && rise.p1 && start_in |=> token[2:0] == 3'h7)
        else $error("simultaneous pulse does not cover a group");
    phase_only_a: assert property (!successive && !rise.p1 ##1 !successive |-> token == $past(token))
        else $error("token moved without phase one edge");
    cascade_dir_a: assert property (direction_right_in |-> cascade_left_pin_oe_out && !cascade_right_pin_oe_out)
        else $error("cascade pin roles wrong");
    bank_hold_a: assert property (strobe_fall ##1 !strobe_fall [*2] |-> $stable(bank_sel))
        else $error("bank swapped without strobe");

    mosaic_line_c: cover property (cfg.array == css_pkg::CSS_MOSAIC && strobe_fall && colour_cnt == 3'h3);
    carry_out_c: cover property (carry && cfg.right_shift);
    double_left_c: cover property (cfg.array == css_pkg::CSS_DOUBLE && !cfg.right_shift && |wr_en1);
endmodule
`default_nettype wire

// [src/css_map.svh]
// constants of the column sampling sequencer
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_COLS       240
`define CSS_VIDEO_W    8
`define CSS_GROUP      3
`define CSS_CNT_RST    3'h0
`define CSS_CNT_FIRST  3'h1
`define CSS_CNT_LAST   3'h6
`define CSS_BANK_RST   1'b0
`endif

// [src/css_pkg.sv]
// types shared by the column sampling sequencer
package css_pkg;
    // codes are {array_select_hi, array_select_lo}
    typedef enum logic [1:0] {
        CSS_STRIPE = 2'h0,
        CSS_SINGLE = 2'h1,
        CSS_MOSAIC = 2'h2,
        CSS_DOUBLE = 2'h3
    } css_array_t;

    typedef struct packed {
        logic       right_shift;
        css_array_t array;
    } css_cfg_t;

    typedef struct packed {
        logic p3;
        logic p2;
        logic p1;
    } css_phase_t;
endpackage

// [src/css_hold_bank.sv]
// one sample-and-hold bank: per-column write strobes, registered parallel read
`timescale 1ns/1ps
`default_nettype none
module css_hold_bank #(
    parameter int COLS = 240,
    parameter int W    = 8
) (
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    // write side
    input  wire logic [COLS-1:0]   wr_en_in,
    input  wire logic [COLS*W-1:0] wr_data_in,
    // read side
    output logic      [COLS*W-1:0] rd_data_out
);
    for (genvar c = 0; c < COLS; c++) begin : g_col
        always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
                rd_data_out[c*W +: W] <= '0;
            end else if (wr_en_in[c]) begin
                // tracks the input for as long as the pulse stands
                rd_data_out[c*W +: W] <= wr_data_in[c*W +: W];
            end
        end
    end
endmodule
`default_nettype wire

// [tb/css_ctrl_model.sv]
// display timing controller model: shift clock phases, line strobe, start pulse
`timescale 1ns/1ps
`default_nettype none
module css_ctrl_model (
    // clock
    input  wire logic  clock_in,
    // timing to the sequencer
    output logic [2:0] phase_out,
    output logic       strobe_out,
    output logic       start_out
);
    initial begin
        phase_out = 3'h0;
        strobe_out = 1'b0;
        start_out = 1'b0;
    end

    // strobe for 18 steps with clocks running, then start and a scan long enough for the carry
    task automatic run_line(input logic succ, input logic strobe);
        for (int k = 0; k < (succ ? 264 : 184); k++) begin
            @(posedge clock_in);
            if (succ)
                phase_out <= 3'h1 << (k % 3);
            else
                phase_out <= {2'h0, ~k[0]};
            strobe_out <= strobe && (k < 18);
            start_out <= (k == 18);
        end
        @(posedge clock_in);
        phase_out <= 3'h0;
    endtask
endmodule
`default_nettype wire

// [tb/css_sequencer_test.sv]
// self-checking bench of the column sampling sequencer
`timescale 1ns/1ps
`default_nettype none
`include "css_map.svh"
module css_sequencer_test;
    localparam int COLS = `CSS_COLS;
    localparam int W    = `CSS_VIDEO_W;
    logic              clock_in, sys_rst_in, dir, strobe, start;
    logic              r_out, r_oe, l_out, l_oe, col_oe;
    logic [1:0]        mode;
    logic [2:0]        phase;
    logic [W-1:0]      va, vb, vc, pa, pb, pc;
    logic [COLS*W-1:0] cols;
    logic [COLS-1:0]   pulses;
    logic [31:0]       seed = 32'h447B;
    int                n_errors = 0, cmp_count = 0, cycles = 0, carry_n, cnt, prev_cnt;

    css_ctrl_model ctrl_i (.clock_in(clock_in), .phase_out(phase), .strobe_out(strobe),
        .start_out(start));
    css_sequencer css_sequencer_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .shift_clock_phase_in(phase), .line_strobe_in(strobe),
        .array_select_hi_in(mode[1]), .array_select_lo_in(mode[0]),
        .direction_right_in(dir), .video_in_a_in(va), .video_in_b_in(vb), .video_in_c_in(vc),
        .cascade_right_pin_in(r_oe ? r_out : start), .cascade_right_pin_out(r_out),
        .cascade_right_pin_oe_out(r_oe), .cascade_left_pin_in(l_oe ? l_out : start),
        .cascade_left_pin_out(l_out), .cascade_left_pin_oe_out(l_oe),
        .column_outputs_out(cols), .column_outputs_oe_out(col_oe), .sampling_pulse_out(pulses));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (dir ? l_out : r_out)
            carry_n++;
        if (cycles == 40000) begin
            n_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // colour of column c sampled while the select counter was n
    function automatic logic [W-1:0] exp_col(input int c, input int n);
        int r;
        int idx;
        if (n == 0 && mode != css_pkg::CSS_STRIPE)
            return '0;
        case (mode)
            css_pkg::CSS_SINGLE: r = n % 2 ? 0 : 1;
            css_pkg::CSS_MOSAIC: r = (3 - (n - 1) % 3) % 3;
            css_pkg::CSS_DOUBLE: r = (n % 2) ^ !dir;
            default:             r = 0;
        endcase
        idx = (c % 3 + r) % 3;
        return idx == 0 ? pa : (idx == 1 ? pb : pc);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_line(input int ln);
        int lo;
        repeat (5) @(negedge clock_in);
        chk("column oe", 32'(ln == 0), 32'(col_oe));
        chk("right cascade oe", 32'(!dir), 32'(r_oe));
        chk("left cascade oe", 32'(dir), 32'(l_oe));
        repeat (30) @(negedge clock_in);
        chk("column oe", 32'h1, 32'(col_oe));
        // start taken 15 clocks before this point: 15 phase edges or 8 phase one edges
        lo = -1;
        for (int i = COLS - 1; i >= 0; i--)
            if (pulses[i])
                lo = i;
        chk("pulse count", (mode == css_pkg::CSS_STRIPE) ? 32'h3 : 32'h1, 32'($countones(pulses)));
        chk("pulse position", (mode == css_pkg::CSS_STRIPE) ? 32'h15 : 32'hE, 32'(lo));
        if (ln > 0)
            for (int c = 0; c < COLS; c++)
                chk("column", 32'(exp_col(c, prev_cnt)), 32'(cols[c*W +: W]));
    endtask

    task automatic summarize;
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // every array mode in both directions, a strobe-less line after each reset
    initial begin
        sys_rst_in = 1'b1;
        dir = 1'b0;
        mode = 2'h0;
        {va, vb, vc} = '0;
        for (int m = 0; m < 8; m++) begin
            mode <= m[1:0];
            dir <= m[2];
            sys_rst_in <= 1'b1;
            repeat (8) @(posedge clock_in);
            sys_rst_in <= 1'b0;
            cnt = 0;
            for (int ln = 0; ln < 8; ln++) begin
                pa = va;
                pb = vb;
                pc = vc;
                prev_cnt = cnt;
                seed = xs(seed);
                // corner: all-zero and all-one samples on one line
                if (ln == 3)
                    seed = 32'h005A_FF00;
                va <= seed[W-1:0];
                vb <= seed[2*W-1:W];
                vc <= seed[3*W-1:2*W];
                if (ln > 0)
                    cnt = cnt == 6 ? 1 : cnt + 1;
                carry_n = 0;
                fork
                    ctrl_i.run_line(mode != css_pkg::CSS_STRIPE, ln > 0);
                    check_line(ln);
                join
                chk("carry", 32'h1, 32'(carry_n > 0));
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
